// file: bench/ppw_core_tb.sv
// self-checking bench for the wait timing and slave buffer block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module ppw_core_tb;
   import ppw_pkg::*;
   logic        clk;
   logic        resetn;
   ppw_reg_t    reg_req;
   logic [15:0] rdata;
   logic        irq;
   ppw_host_t   host;
   logic [7:0]  host_rdata;
   logic        strobe;
   logic        bus_busy;
   logic        in_ttl;
   logic [15:0] v;
   logic [7:0]  b;
   logic        rd;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n, h, cs, cst, ch;

   ppw_core dut (.clk(clk), .resetn(resetn), .reg_req(reg_req), .rdata(rdata), .irq(irq),
      .host(host), .host_rdata(host_rdata), .strobe(strobe), .bus_busy(bus_busy),
      .input_threshold_sel(in_ttl));
   ppw_host_model hm (.clk(clk), .host(host), .host_rdata(host_rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) reg_req.wr <= 1'b0;
      // let the edge that takes the write settle before anyone looks
      #1;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk) reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk) reg_req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic stat_is(input logic [15:0] e);
      reg_rd(OFF_BUF_STAT, v);
      `CHK("status", e, v)
   endtask

   task automatic end_sim;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic t_reset;
      stat_is(16'h008f);
      reg_rd(4'hf, v);
      `CHK("unmapped", 16'h0000, v)
      reg_wr(OFF_PAD_CFG, 16'h0001);
      `CHK("ttl select", 1'b1, in_ttl)
   endtask

   task automatic t_inbuf;
      reg_wr(OFF_IRQ_MASK, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         hm.put(i[1:0], 8'h10 + i[7:0]);
      end
      stat_is(16'h8f8f);
      `CHK("irq masked", 1'b0, irq)
      hm.put(2'd1, 8'h55);
      stat_is(16'hcf8f);
      `CHK("irq raised", 1'b1, irq)
      reg_rd(OFF_INBUF0, v);
      `CHK("inbuf byte0", 8'h10, v[7:0])
      stat_is(16'h4c8f);
      reg_wr(OFF_BUF_STAT, 16'h3030);
      stat_is(16'h0c8f);
      reg_rd(OFF_IRQ_STAT, v);
      `CHK("irq events", 4'h5, v[3:0])
      reg_wr(OFF_IRQ_STAT, 16'h000f);
      `CHK("irq cleared", 1'b0, irq)
   endtask

   task automatic t_outbuf;
      reg_wr(OFF_OUTBUF0, 16'h2a1b);
      stat_is(16'h0c0c);
      hm.get(2'd0, b);
      `CHK("host byte0", 8'h1b, b)
      hm.get(2'd2, b);
      stat_is(16'h0c4d);
   endtask

   task automatic t_timing;
      for (int s = 0; s < 4; s++) begin
         n = (s == 3) ? 15 : s;
         h = 1 + s % 3;
         rd = s[0];
         reg_wr(OFF_CS_MODE, 16'((s << SETUP_LSB) | (n << STROBE_LSB) | (h << HOLD_LSB)));
         reg_wr(OFF_ACCESS, {15'h0000, rd});
         cs = 0;
         cst = 0;
         ch = 0;
         for (int k = 0; k < 60; k++) begin
            #1;
            if (bus_busy === 1'b1 && strobe !== 1'b1) begin
               if (cst == 0) cs++;
               else ch++;
            end
            if (strobe === 1'b1) cst++;
            @(posedge clk);
         end
         `CHK("setup cycles", s + 1, cs)
         `CHK("strobe cycles", n + 1, cst)
         `CHK("hold cycles", rd ? h : h + 1, ch)
      end
      reg_rd(OFF_IRQ_STAT, v);
      `CHK("access done", 1'b1, v[EV_DONE])
   endtask

   initial begin
      resetn = 1'b0;
      reg_req = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_inbuf();
      t_outbuf();
      t_timing();
      end_sim();
   end

   // whole run needs well under 1000 cycles
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule

// file: bench/ppw_host_model.sv
// external host model driving the slave byte buffers
`timescale 1ns/1ps
module ppw_host_model (
   // clock
   input  wire logic         clk,
   // host bus
   output ppw_pkg::ppw_host_t host,
   input  wire logic [7:0]   host_rdata
);
   import ppw_pkg::*;

   initial host = '0;

   task automatic put(input logic [1:0] sel, input logic [7:0] d);
      @(posedge clk) host <= '{wr: 1'b1, rd: 1'b0, byte_sel: sel, data: d};
      // released data lines show the inverse, never a stale copy
      @(posedge clk) host <= '{wr: 1'b0, rd: 1'b0, byte_sel: sel, data: ~d};
   endtask

   task automatic get(input logic [1:0] sel, output logic [7:0] d);
      @(posedge clk) host <= '{wr: 1'b0, rd: 1'b1, byte_sel: sel, data: ~host.data};
      @(posedge clk) host.rd <= 1'b0;
      #1 d = host_rdata;
   endtask
endmodule

// file: core/ppw_core.sv
// parallel port master wait timing and slave buffer status logic
//
// Summary of operation
// RULE_01: setup wait 1.25..3.25 cycles by field; code gives 0.25..3.25 for field 0..3
// RULE_02: strobe n+0.5 write, n+0.75 read
// RULE_03: all-full flag when every input byte full
// RULE_04: host write to full byte sets overflow
// RULE_05: per-byte unread flag, host sets, read clears
// RULE_06: all-empty flag when outputs empty, resets one
// RULE_07: host read of empty byte sets underflow
// RULE_08: per-byte empty flag, local write clears
// RULE_09: local read clears both bytes of word
// RULE_10: status bits 13:12, 5:4 read zero
// RULE_11: hold wait after strobe, order setup-strobe-hold
`timescale 1ns/1ps
module ppw_core
   import ppw_pkg::*;
#(
   parameter int QDIV = 4
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // register port
   input  wire ppw_pkg::ppw_reg_t reg_req,
   output logic [15:0]            rdata,
   output logic                   irq,
   // external host, slave side
   input  wire ppw_pkg::ppw_host_t host,
   output logic [7:0]             host_rdata,
   // master side strobe timing and input threshold select
   output logic                   strobe,
   output logic                   bus_busy,
   output logic                   input_threshold_sel
);
   import ppw_pkg::*;

   logic [15:0] chip_select_mode;
   logic        nonport_io_ctl;
   logic [7:0]  inbuf [4];
   logic [7:0]  outbuf [4];
   logic [3:0]  inbuf_byte_full;
   logic [3:0]  outbuf_byte_empty;
   logic        inbuf_overflow;
   logic        outbuf_underflow;
   logic [3:0]  irq_stat;
   logic [3:0]  irq_mask;
   ppw_state_t  state;
   logic [7:0]  qcount;
   logic        acc_rd;
   logic [1:0]  qtick;

   wire [1:0] setup_wait_sel  = chip_select_mode[SETUP_LSB+:2];
   wire [3:0] strobe_wait_sel = chip_select_mode[STROBE_LSB+:4];
   wire [1:0] hold_wait_sel   = chip_select_mode[HOLD_LSB+:2];

   // RULE_01 setup length
   wire [7:0] setup_q = {4'h0, 2'b00, setup_wait_sel} * 8'd4 + SETUP_FRAC_Q;
   // RULE_02 strobe length
   wire [7:0] strobe_q = {4'h0, strobe_wait_sel} * 8'd4 + (acc_rd ? RD_FRAC_Q : WR_FRAC_Q);
   // RULE_11 hold length
   wire [7:0] hold_q = {6'h00, hold_wait_sel} * 8'd4 + (acc_rd ? 8'h00 : HOLD_WR_Q);

   wire w_en   = reg_req.wr;
   wire r_en   = reg_req.rd;
   wire [3:0] a = reg_req.addr;
   wire start  = w_en && a == OFF_ACCESS && state == PPW_IDLE;

   // RULE_03 summary of input bytes
   wire inbuf_all_full   = &inbuf_byte_full;
   // RULE_06 summary of output bytes
   wire outbuf_all_empty = &outbuf_byte_empty;

   // RULE_10 unimplemented bits zero
   wire [15:0] stat_word = {inbuf_all_full, inbuf_overflow, 2'b00, inbuf_byte_full,
                            outbuf_all_empty, outbuf_underflow, 2'b00, outbuf_byte_empty};

   wire host_ovf = host.wr && inbuf_byte_full[host.byte_sel];
   wire host_unf = host.rd && outbuf_byte_empty[host.byte_sel];
   wire ib_rd0   = r_en && a == OFF_INBUF0;
   wire ib_rd1   = r_en && a == OFF_INBUF1;
   wire ob_wr0   = w_en && a == OFF_OUTBUF0;
   wire ob_wr1   = w_en && a == OFF_OUTBUF1;
   wire done_ev  = state == PPW_HOLD && qcount <= 8'd4;
   wire [3:0] ev = {done_ev, inbuf_all_full, host_unf, host_ovf};

   // time base in quarters: four quarters per cycle, one count step per cycle
   // means sub-cycle fractions round each phase up to whole cycles
   wire [7:0] q_step = 8'd4;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state  <= PPW_IDLE;
         qcount <= 8'h00;
         acc_rd <= 1'b0;
      end else begin
         // RULE_11 setup, strobe, hold in order
         case (state)
            PPW_IDLE: if (start) begin
               acc_rd <= reg_req.wdata[0];
               qcount <= setup_q;
               state  <= PPW_SETUP;
            end
            PPW_SETUP: if (qcount <= q_step) begin
               qcount <= strobe_q;
               state  <= PPW_STROBE;
            end else qcount <= qcount - q_step;
            PPW_STROBE: if (qcount <= q_step) begin
               qcount <= hold_q;
               state  <= (hold_q == 8'h00) ? PPW_IDLE : PPW_HOLD;
            end else qcount <= qcount - q_step;
            PPW_HOLD: if (qcount <= q_step) begin
               state <= PPW_IDLE;
            end else qcount <= qcount - q_step;
            default: state <= PPW_IDLE;
         endcase
      end
   end

   assign strobe   = state == PPW_STROBE;
   assign bus_busy = state != PPW_IDLE;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_byte
         wire h_wr = host.wr && host.byte_sel == 2'(i);
         // RULE_09 word-wide clear on local read
         wire l_rd = (i < 2) ? ib_rd0 : ib_rd1;
         // RULE_08 local write clears empty flag
         wire l_wr = (i < 2) ? ob_wr0 : ob_wr1;
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               inbuf_byte_full[i]   <= 1'b0;
               outbuf_byte_empty[i] <= 1'b1;
               inbuf[i]             <= 8'h00;
               outbuf[i]            <= 8'h00;
            end else begin
               // RULE_05 host write sets, set wins over read clear
               if (h_wr) begin
                  inbuf_byte_full[i] <= 1'b1;
                  inbuf[i]           <= host.data;
               end else if (l_rd) inbuf_byte_full[i] <= 1'b0;
               if (l_wr) begin
                  outbuf_byte_empty[i] <= 1'b0;
                  outbuf[i]            <= reg_req.wdata[(i%2)*8+:8];
               end else if (host.rd && host.byte_sel == 2'(i)) outbuf_byte_empty[i] <= 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chip_select_mode    <= CS_MODE_RST;
         nonport_io_ctl      <= 1'b0;
         input_threshold_sel <= 1'b0;
         inbuf_overflow      <= 1'b0;
         outbuf_underflow    <= 1'b0;
         irq_stat            <= 4'h0;
         irq_mask            <= 4'h0;
         rdata               <= 16'h0000;
         host_rdata          <= 8'h00;
      end else begin
         if (w_en && a == OFF_CS_MODE) chip_select_mode <= reg_req.wdata;
         if (w_en && a == OFF_PAD_CFG) begin
            nonport_io_ctl      <= reg_req.wdata[15];
            input_threshold_sel <= reg_req.wdata[0];
         end
         if (w_en && a == OFF_IRQ_MASK) irq_mask <= reg_req.wdata[3:0];
         // RULE_04 sticky overflow, software clear, set wins
         if (host_ovf) inbuf_overflow <= 1'b1;
         else if (w_en && a == OFF_BUF_STAT && !reg_req.wdata[ST_INBUF_OVERFLOW]) inbuf_overflow <= 1'b0;
         // RULE_07 sticky underflow, software clear, set wins
         if (host_unf) outbuf_underflow <= 1'b1;
         else if (w_en && a == OFF_BUF_STAT && !reg_req.wdata[ST_OUTBUF_UNDERFLOW]) outbuf_underflow <= 1'b0;
         irq_stat <= ev | (irq_stat & ~((w_en && a == OFF_IRQ_STAT) ? reg_req.wdata[3:0] : 4'h0));
         if (host.rd) host_rdata <= outbuf[host.byte_sel];
         rdata <= 16'h0000;
         if (r_en) begin
            case (a)
               OFF_CS_MODE:  rdata <= chip_select_mode;
               OFF_BUF_STAT: rdata <= stat_word;
               OFF_PAD_CFG:  rdata <= {nonport_io_ctl, 14'h0000, input_threshold_sel};
               OFF_IRQ_STAT: rdata <= {12'h000, irq_stat};
               OFF_IRQ_MASK: rdata <= {12'h000, irq_mask};
               OFF_INBUF0:   rdata <= {inbuf[1], inbuf[0]};
               OFF_INBUF1:   rdata <= {inbuf[3], inbuf[2]};
               OFF_ACCESS:   rdata <= {15'h0000, bus_busy};
               default:      rdata <= 16'h0000;
            endcase
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // assertions
   ibf_summary_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
      stat_word[ST_IBF] == (&inbuf_byte_full)) else $error("full summary wrong");
   obe_summary_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
      stat_word[ST_OBE] == (&outbuf_byte_empty)) else $error("empty summary wrong");
   ovf_sticky_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
      host_ovf |=> inbuf_overflow) else $error("overflow not set");
   unf_sticky_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
      host_unf |=> outbuf_underflow) else $error("underflow not set");
   byte_set_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
      host.wr |=> inbuf_byte_full[$past(host.byte_sel)]) else $error("byte full not set");
   word_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
      ib_rd0 && !host.wr |=> !inbuf_byte_full[0] && !inbuf_byte_full[1])
      else $error("word clear failed");
   ob_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
      ob_wr1 && !host.rd |=> !outbuf_byte_empty[2] && !outbuf_byte_empty[3])
      else $error("empty not cleared");
   zero_bits_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
      stat_word[13:12] == 2'b00 && stat_word[5:4] == 2'b00) else $error("reserved bits set");
   setup_order_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
      start && setup_wait_sel == 2'b11 |=> state == PPW_SETUP [*4] ##1 state == PPW_STROBE)
      else $error("setup length wrong");
   strobe_len_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
      $rose(strobe) && strobe_wait_sel == 4'h0 |-> ##1 !strobe) else $error("strobe length wrong");
   hold_after_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
      $fell(strobe) && hold_wait_sel != 2'b00 |-> state == PPW_HOLD) else $error("order broken");

   // sticky error flags: only software may clear them
   ovf_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
      inbuf_overflow && !(w_en && a == OFF_BUF_STAT) |=> inbuf_overflow)
      else $error("overflow lost");
   ovf_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
      w_en && a == OFF_BUF_STAT && !reg_req.wdata[ST_INBUF_OVERFLOW] && !host_ovf |=> !inbuf_overflow)
      else $error("overflow not cleared");
   ovf_quiet_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
      !inbuf_overflow && !host_ovf |=> !inbuf_overflow) else $error("overflow without cause");
   unf_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
      outbuf_underflow && !(w_en && a == OFF_BUF_STAT) |=> outbuf_underflow)
      else $error("underflow lost");
   unf_clear_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
      w_en && a == OFF_BUF_STAT && !reg_req.wdata[ST_OUTBUF_UNDERFLOW] && !host_unf |=> !outbuf_underflow)
      else $error("underflow not cleared");

   // per-byte and summary flags follow only their own events; reserved bits read zero
   byte_keep_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
      inbuf_byte_full[0] && !ib_rd0 |=> inbuf_byte_full[0]) else $error("byte full lost");
   word_clear_hi_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
      ib_rd1 && !host.wr |=> !inbuf_byte_full[2] && !inbuf_byte_full[3])
      else $error("upper word clear failed");
   ibf_rise_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
      host.wr && (&(inbuf_byte_full | (4'b0001 << host.byte_sel))) && !ib_rd0 && !ib_rd1
      |=> inbuf_all_full) else $error("full summary not set");
   ob_clear_lo_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
      ob_wr0 && !host.rd |=> !outbuf_byte_empty[0] && !outbuf_byte_empty[1])
      else $error("low empty not cleared");
   ob_keep_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
      !outbuf_byte_empty[0] && !(host.rd && host.byte_sel == 2'd0) |=> !outbuf_byte_empty[0])
      else $error("empty set without read");
   obe_fall_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
      ob_wr0 && !host.rd |=> !outbuf_all_empty) else $error("empty summary not cleared");
   zero_read_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
      r_en && a == OFF_BUF_STAT |=> rdata[13:12] == 2'b00 && rdata[5:4] == 2'b00)
      else $error("reserved bits read back");

   // access phase lengths for the codes the bench drives
   setup_short_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
      start && setup_wait_sel == 2'b01 |=> state == PPW_SETUP ##1 state == PPW_SETUP
      ##1 state == PPW_STROBE) else $error("short setup wrong");
   strobe_two_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
      $rose(strobe) && strobe_wait_sel == 4'h1 |-> strobe ##1 strobe ##1 !strobe)
      else $error("strobe of two wrong");
   strobe_long_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
      $rose(strobe) && strobe_wait_sel == 4'hf |-> strobe [*8] ##1 strobe [*8] ##1 !strobe)
      else $error("long strobe wrong");
   hold_rd_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
      $fell(strobe) && acc_rd && hold_wait_sel == 2'b01 |-> state == PPW_HOLD
      ##1 state == PPW_IDLE) else $error("read hold wrong");
   hold_wr_a: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
      $fell(strobe) && !acc_rd && hold_wait_sel == 2'b01 |-> state == PPW_HOLD
      ##1 state == PPW_HOLD ##1 state == PPW_IDLE) else $error("write hold wrong");
endmodule

// file: core/ppw_pkg.sv
// package for the parallel port wait-state and slave buffer block
package ppw_pkg;
   // register offsets (word index, byte address = 4 * index)
   localparam logic [3:0] OFF_CS_MODE   = 4'h0;
   localparam logic [3:0] OFF_BUF_STAT  = 4'h1;
   localparam logic [3:0] OFF_PAD_CFG   = 4'h2;
   localparam logic [3:0] OFF_IRQ_STAT  = 4'h3;
   localparam logic [3:0] OFF_IRQ_MASK  = 4'h4;
   localparam logic [3:0] OFF_INBUF0    = 4'h5;
   localparam logic [3:0] OFF_INBUF1    = 4'h6;
   localparam logic [3:0] OFF_OUTBUF0   = 4'h7;
   localparam logic [3:0] OFF_OUTBUF1   = 4'h8;
   localparam logic [3:0] OFF_ACCESS    = 4'h9;
   // chip select mode fields
   localparam int SETUP_LSB  = 6;
   localparam int STROBE_LSB = 2;
   localparam int HOLD_LSB   = 0;
   // status bit positions
   localparam int ST_IBF  = 15;
   localparam int ST_INBUF_OVERFLOW = 14;
   localparam int ST_OBE  = 7;
   localparam int ST_OUTBUF_UNDERFLOW = 6;
   // reset values
   localparam logic [15:0] CS_MODE_RST = 16'h0000;
   localparam logic [3:0]  OB_EMPTY_RST = 4'hf;
   // waits in quarter cycles; internal tick = 4x slower count of quarters
   localparam int QUARTERS = 4;
   localparam logic [7:0] SETUP_FRAC_Q = 8'h01;
   localparam logic [7:0] WR_FRAC_Q    = 8'h02;
   localparam logic [7:0] RD_FRAC_Q    = 8'h03;
   localparam logic [7:0] HOLD_WR_Q    = 8'h01;
   // interrupt event bits
   localparam int EV_OVF   = 0;
   localparam int EV_UNF   = 1;
   localparam int EV_IFULL = 2;
   localparam int EV_DONE  = 3;

   typedef enum {PPW_IDLE, PPW_SETUP, PPW_STROBE, PPW_HOLD} ppw_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  byte_sel;
      logic [7:0]  data;
   } ppw_host_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ppw_reg_t;
endpackage
